// [common/hdlrx_map.vh]
// register map, field positions, reset values and counts of the receiver
`ifndef HDLRX_MAP_VH
`define HDLRX_MAP_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define HDLRX_ADDR_CTRL    12'h000
`define HDLRX_ADDR_THRESH  12'h004
`define HDLRX_ADDR_STATUS  12'h008
`define HDLRX_ADDR_STICKY  12'h00c
`define HDLRX_ADDR_DATA    12'h010

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define HDLRX_CTRL_INVERT  0
`define HDLRX_CTRL_SOURCE  1
`define HDLRX_CTRL_FCSEN   2
`define HDLRX_CTRL_REORDER 3
`define HDLRX_CTRL_RESET   4'h0
`define HDLRX_THRESH_RESET 9'h001

// ----------------------------------------------------------------------
// status and sticky fields
// ----------------------------------------------------------------------
`define HDLRX_ST_EMPTY     0
`define HDLRX_ST_AVAIL     1
`define HDLRX_ST_FULL      2
`define HDLRX_ST_LEVEL_LO  16
`define HDLRX_SK_OVERFLOW  0
`define HDLRX_SK_INVALID   1
`define HDLRX_SK_FCSERR    2
`define HDLRX_SK_ABORT     3

// ----------------------------------------------------------------------
// fifo entry layout: byte in [7:0], packet status above it
// ----------------------------------------------------------------------
`define HDLRX_E_START      8
`define HDLRX_E_END        9
`define HDLRX_E_ABORT      10
`define HDLRX_E_FCSERR     11
`define HDLRX_D_INVALID    12

// ----------------------------------------------------------------------
// line coding constants
// ----------------------------------------------------------------------
`define HDLRX_FLAG         8'h7e
`define HDLRX_CRC_INIT     16'hffff
`define HDLRX_CRC_POLY     16'h8408
`define HDLRX_CRC_GOOD     16'hf0b8
`define HDLRX_MIN_BITS     5'h10
`define HDLRX_RESTART_FREE 9'h010
`define HDLRX_FLAG_SKIP    4'h7

`endif

// [rtl/hdlrx_receiver.v]
// receive half of the overhead packet controller with its byte fifo
//
// Operation
// - optionally complement every bit after source select
// - select line framer or plcp framer source
// - discard all fill between end and start flags
// - drop under sixteen bits between flags
// - seven ones abort packet, hunt next flag
// - delete zero after five ones inside packet
// - pack bytes with start, end, abort status
// - short last byte marks packet aborted invalid
// - trailing five ones still a normal packet
// - fcs on: check, strip two bytes, flag
// - fcs off: pass every byte unchecked
// - reorder off: first bit to bit 0
// - reorder on: first bit to bit 7
// - 256 byte fifo with pointers, level
// - report empty, threshold available, full
// - start byte into full fifo dropped, overflow
// - other byte into full: abort packet, overflow
// - after overflow wait start with sixteen free
// - one byte per read; empty read flagged invalid
// - byte based; reads only through registers
// - storage reachable from either side independently
`timescale 1ns/10ps
`default_nettype none
`include "hdlrx_map.vh"

module hdlrx_receiver #(
    parameter DEPTH_LOG2 = 8                  // fifo of 256 bytes
) (
    input  wire        mclk,                  // system clock, 100 MHz
    input  wire        nrst,                  // async reset, active low
    input  wire        lineClk,               // line framer bit clock pin
    input  wire        lineData,              // line framer overhead bit
    input  wire        plcpClk,               // plcp framer bit clock pin
    input  wire        plcpData,              // plcp framer overhead bit
    input  wire        psel,                  // apb select
    input  wire        penable,               // apb access phase
    input  wire        pwrite,                // apb direction
    input  wire [11:0] paddr,                 // apb byte address
    input  wire [31:0] pwdata,                // apb write data
    output wire        pready,                // apb ready
    output reg  [31:0] prdata,                // apb read data
    output wire        pslverr                // apb error, unmapped address
);

    localparam DEPTH = 1 << DEPTH_LOG2;       // entries in the fifo
    localparam HUNT  = 1'b0;                  // searching for a start flag
    localparam INPKT = 1'b1;                  // between start and end flag

    // ------------------------------------------------------------------
    // pin synchronisers: three stages, a change counts when 2 and 3 agree
    // ------------------------------------------------------------------
    wire [3:0] pinRaw = {plcpData, plcpClk, lineData, lineClk};
    reg  [3:0] syncA;                         // first stage, read by syncB only
    reg  [3:0] syncB;                         // second stage
    reg  [3:0] syncC;                         // third stage
    reg  [3:0] pinStable;                     // accepted pin levels
    reg        prevClk;                       // selected clock, last cycle
    reg  [3:0] ctrl;                          // control register
    genvar gi;

    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
            // a level is taken only once two stages agree, so a
            // metastable settle never yields a false edge
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    syncA[gi]     <= 1'b0;
                    syncB[gi]     <= 1'b0;
                    syncC[gi]     <= 1'b0;
                    pinStable[gi] <= 1'b0;
                end else begin
                    syncA[gi] <= pinRaw[gi];
                    syncB[gi] <= syncA[gi];
                    syncC[gi] <= syncB[gi];
                    if (syncB[gi] == syncC[gi]) begin
                        pinStable[gi] <= syncC[gi];
                    end
                end
            end
        end
    endgenerate

    // source mux after the synchronisers, then optional inversion
    wire selClk  = ctrl[`HDLRX_CTRL_SOURCE] ? pinStable[2] : pinStable[0];
    wire selData = ctrl[`HDLRX_CTRL_SOURCE] ? pinStable[3] : pinStable[1];
    wire bitIn   = selData ^ ctrl[`HDLRX_CTRL_INVERT];
    wire bitStb  = selClk & ~prevClk;         // one pulse per line bit

    // ------------------------------------------------------------------
    // receive bit path state
    // ------------------------------------------------------------------
    reg  [6:0]  window;                       // last seven line bits
    reg         rxState;                      // hunt or in packet
    reg  [3:0]  skipCnt;                      // flag bits still to leave
    reg  [2:0]  dataOnes;                     // ones run in packet data
    reg  [2:0]  bitCnt;                       // bits in byte being built
    reg  [7:0]  asm;                          // byte being built
    reg  [4:0]  totalBits;                    // packet bits, saturates at 16
    reg  [15:0] crc;                          // running fcs
    reg  [7:0]  hold0;                        // newest completed byte
    reg  [7:0]  hold1;
    reg  [7:0]  hold2;                        // oldest, used with fcs
    reg  [1:0]  holdCnt;                      // bytes held back
    reg         startPend;                    // start not yet written
    reg         fcsSeen;                      // sticky-set pulse for fcs error
    reg         abortSeen;                    // sticky-set pulse for abort

    wire [7:0] nextWindow = {window, bitIn};
    wire       oldBit     = window[6];        // oldest bit, to the data path
    wire       isFlag     = nextWindow == `HDLRX_FLAG;
    wire       isAbort    = nextWindow[6:0] == 7'h7f;
    wire [1:0] holdDepth  = ctrl[`HDLRX_CTRL_FCSEN] ? 2'h3 : 2'h1;
    wire [7:0] holdOldest = ctrl[`HDLRX_CTRL_FCSEN] ? hold2 : hold0;
    wire       doData     = (rxState == INPKT) && (skipCnt == 4'h0);
    wire       stuffed    = (dataOnes == 3'h5) && !oldBit;
    wire       takeBit    = doData && !stuffed;
    wire       byteDone   = takeBit && (bitCnt == 3'h7);
    wire [7:0] newByte    = {oldBit, asm[7:1]};  // first bit ends in bit 0
    wire       crcFb      = crc[0] ^ oldBit;
    wire [15:0] crcStep   = {1'b0, crc[15:1]} ^
                            (crcFb ? `HDLRX_CRC_POLY : 16'h0000);

    // byte handed to the fifo, one cycle pulse
    reg        wrReq;
    reg [11:0] wrEntry;

    // bit order of the stored byte
    function [7:0] reorder;
        input [7:0] b;
        input       rev;
        integer     k;
        begin
            reorder = b;
            for (k = 0; k < 8; k = k + 1) begin
                if (rev) begin
                    reorder[k] = b[7-k];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // delineation, abort, destuffing, packing and fcs per line bit
    // ------------------------------------------------------------------
    // flags and aborts are seen in the window before any of their bits
    // reach the data path, so neither leaks into a packet byte
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prevClk   <= 1'b0;
            window    <= 7'h00;
            rxState   <= HUNT;
            skipCnt   <= 4'h0;
            dataOnes  <= 3'h0;
            bitCnt    <= 3'h0;
            asm       <= 8'h00;
            totalBits <= 5'h00;
            crc       <= `HDLRX_CRC_INIT;
            hold0     <= 8'h00;
            hold1     <= 8'h00;
            hold2     <= 8'h00;
            holdCnt   <= 2'h0;
            startPend <= 1'b0;
            wrReq     <= 1'b0;
            wrEntry   <= 12'h000;
            fcsSeen   <= 1'b0;
            abortSeen <= 1'b0;
        end else begin
            prevClk   <= selClk;
            wrReq     <= 1'b0;
            fcsSeen   <= 1'b0;
            abortSeen <= 1'b0;
            if (bitStb) begin
                window <= nextWindow[6:0];
                if (isFlag) begin
                    // end of a packet, if one was open
                    if (rxState == INPKT && totalBits >= `HDLRX_MIN_BITS) begin
                        if (bitCnt != 3'h0) begin
                            // short last byte: close as aborted, invalid
                            wrReq   <= !startPend;
                            wrEntry <= {4'b0110,
                                reorder(hold0, ctrl[`HDLRX_CTRL_REORDER])};
                            abortSeen <= 1'b1;
                        end else if (holdCnt == holdDepth) begin
                            wrReq   <= 1'b1;
                            wrEntry <= {ctrl[`HDLRX_CTRL_FCSEN] &&
                                        crc != `HDLRX_CRC_GOOD,
                                        1'b0, 1'b1, startPend,
                                reorder(holdOldest, ctrl[`HDLRX_CTRL_REORDER])};
                            fcsSeen <= ctrl[`HDLRX_CTRL_FCSEN] &&
                                       crc != `HDLRX_CRC_GOOD;
                        end
                    end
                    // the flag opens the next packet; its bits are skipped
                    rxState   <= INPKT;
                    skipCnt   <= `HDLRX_FLAG_SKIP;
                    dataOnes  <= 3'h0;
                    bitCnt    <= 3'h0;
                    totalBits <= 5'h00;
                    crc       <= `HDLRX_CRC_INIT;
                    holdCnt   <= 2'h0;
                    startPend <= 1'b1;
                end else if (rxState == INPKT && isAbort) begin
                    // abort: close any written part, then hunt
                    if (!startPend) begin
                        wrReq   <= 1'b1;
                        wrEntry <= {4'b0110,
                            reorder(hold0, ctrl[`HDLRX_CTRL_REORDER])};
                    end
                    abortSeen <= !startPend || skipCnt == 4'h0;
                    rxState   <= HUNT;
                    startPend <= 1'b0;
                end else if (rxState == INPKT) begin
                    if (skipCnt != 4'h0) begin
                        skipCnt <= skipCnt - 4'h1;
                    end
                    if (doData) begin
                        // five ones then a zero: the zero is removed
                        if (stuffed) begin
                            dataOnes <= 3'h0;
                        end else begin
                            dataOnes <= oldBit ? dataOnes + 3'h1 : 3'h0;
                        end
                    end
                    if (takeBit) begin
                        asm    <= newByte;
                        bitCnt <= bitCnt + 3'h1;
                        crc    <= crcStep;
                        if (totalBits != `HDLRX_MIN_BITS) begin
                            totalBits <= totalBits + 5'h01;
                        end
                    end
                    if (byteDone) begin
                        // hold back one byte, or three with fcs so the
                        // two fcs bytes never reach the fifo
                        hold0 <= newByte;
                        hold1 <= hold0;
                        hold2 <= hold1;
                        if (holdCnt == holdDepth) begin
                            wrReq   <= 1'b1;
                            wrEntry <= {3'b000, startPend,
                                reorder(holdOldest, ctrl[`HDLRX_CTRL_REORDER])};
                            startPend <= 1'b0;
                        end else begin
                            holdCnt <= holdCnt + 2'h1;
                        end
                    end
                end
                // in hunt nothing is written: ones fill and noise vanish
            end
        end
    end

    // ------------------------------------------------------------------
    // receive fifo
    // ------------------------------------------------------------------
    reg  [11:0]           mem [0:DEPTH-1];    // byte plus packet status
    reg  [DEPTH_LOG2-1:0] wrPtr;              // next entry to write
    reg  [DEPTH_LOG2-1:0] rdPtr;              // next entry to read
    reg  [DEPTH_LOG2:0]   level;              // stored entries
    reg                   discard;            // dropping after overflow
    reg  [8:0]            thresh;             // data available threshold
    reg  [3:0]            sticky;             // sticky event bits
    reg                   rdArmed;            // pop pending at access
    reg                   markLast;           // abort the last stored entry
    reg                   ovfSet;             // overflow event pulse

    wire fifoEmpty = level == {(DEPTH_LOG2+1){1'b0}};
    wire fifoFull  = level == DEPTH[DEPTH_LOG2:0];
    wire fifoAvail = {{(9-DEPTH_LOG2-1){1'b0}}, level} >= thresh;
    wire [8:0] freeSpace = DEPTH[8:0] - {{(9-DEPTH_LOG2-1){1'b0}}, level};
    wire wrStart   = wrEntry[`HDLRX_E_START];
    wire accept    = wrReq && !fifoFull &&
                     (!discard || (wrStart &&
                      freeSpace >= `HDLRX_RESTART_FREE));

    // apb decode
    wire setup     = psel && !penable;
    wire access    = psel && penable;
    wire mapped    = paddr == `HDLRX_ADDR_CTRL   ||
                     paddr == `HDLRX_ADDR_THRESH ||
                     paddr == `HDLRX_ADDR_STATUS ||
                     paddr == `HDLRX_ADDR_STICKY ||
                     paddr == `HDLRX_ADDR_DATA;
    wire pop       = access && !pwrite && paddr == `HDLRX_ADDR_DATA &&
                     rdArmed;

    assign pready  = access;                  // zero wait states
    assign pslverr = access && !mapped;

    // storage write and overflow handling
    always @(posedge mclk) begin
        if (accept) begin
            mem[wrPtr] <= wrEntry;
        end else if (markLast) begin
            // close the packet already stored with abort and end
            mem[wrPtr - 1'b1] <= mem[wrPtr - 1'b1] | 12'h600;
        end
    end

    // pointers, level and overflow state
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrPtr    <= {DEPTH_LOG2{1'b0}};
            rdPtr    <= {DEPTH_LOG2{1'b0}};
            level    <= {(DEPTH_LOG2+1){1'b0}};
            discard  <= 1'b0;
            markLast <= 1'b0;
            ovfSet   <= 1'b0;
        end else begin
            markLast <= 1'b0;
            ovfSet   <= 1'b0;
            if (accept) begin
                wrPtr   <= wrPtr + 1'b1;
                discard <= 1'b0;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (accept && !pop) begin
                level <= level + 1'b1;
            end else if (!accept && pop) begin
                level <= level - 1'b1;
            end
            if (wrReq && fifoFull) begin
                ovfSet  <= 1'b1;
                discard <= 1'b1;
                // a start byte is simply lost; a later byte means a
                // packet was cut, so its stored part is closed aborted
                markLast <= !wrStart && !discard;
            end
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    // reads are prepared in the setup cycle so prdata leaves a flop;
    // the fifo head is then popped at the access edge
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl    <= `HDLRX_CTRL_RESET;
            thresh  <= `HDLRX_THRESH_RESET;
            sticky  <= 4'h0;
            rdArmed <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            if (access && pwrite && paddr == `HDLRX_ADDR_CTRL) begin
                ctrl <= pwdata[3:0];
            end
            if (access && pwrite && paddr == `HDLRX_ADDR_THRESH) begin
                thresh <= pwdata[8:0];
            end
            // write one to clear; an event in the same cycle wins
            sticky <= (sticky & ~((access && pwrite &&
                       paddr == `HDLRX_ADDR_STICKY) ? pwdata[3:0] : 4'h0))
                    | {abortSeen, fcsSeen,
                       setup && !pwrite && paddr == `HDLRX_ADDR_DATA &&
                       fifoEmpty,
                       ovfSet};
            if (access) begin
                rdArmed <= 1'b0;
            end
            if (setup && !pwrite) begin
                rdArmed <= 1'b0;
                case (paddr)
                    `HDLRX_ADDR_CTRL: begin
                        prdata <= {28'h0, ctrl};
                    end
                    `HDLRX_ADDR_THRESH: begin
                        prdata <= {23'h0, thresh};
                    end
                    `HDLRX_ADDR_STATUS: begin
                        prdata <= {7'h00, level, 13'h0000, fifoFull,
                                   fifoAvail, fifoEmpty};
                    end
                    `HDLRX_ADDR_STICKY: begin
                        prdata <= {28'h0, sticky};
                    end
                    `HDLRX_ADDR_DATA: begin
                        if (fifoEmpty) begin
                            prdata <= 32'h0000_1000;
                        end else begin
                            prdata  <= {20'h00000, mem[rdPtr]};
                            rdArmed <= 1'b1;
                        end
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule // hdlrx_receiver

`default_nettype wire

// [test/hdlrx_line_src.sv]
// partner model: framer overhead bit source with bit clock
`timescale 1ns/10ps
`default_nettype none
module hdlrx_line_src (
    input  wire logic mclk,  // system clock
    output var  logic bclk,  // bit clock, stands low outside frames
    output var  logic bdat   // overhead bit, sampled at bclk rise
);
    logic inv;   // complement every bit sent
    int   ones;  // current run of ones, for stuffing
    initial bclk = 1'b0;
    initial bdat = 1'b0;
    // data settles three cycles before the rise, held five after
    task automatic sbit(input logic b);
        @(posedge mclk) bdat <= b ^ inv;
        repeat (3) @(posedge mclk);
        bclk <= 1'b1;
        repeat (4) @(posedge mclk);
        bclk <= 1'b0;
        ones = b ? ones + 1 : 0;
    endtask
    // flag, k stuffed bytes, flag; flags are never stuffed
    task automatic sframe(input logic [7:0] v [0:5], input int k,
                          input logic iv);
        logic fl;
        inv = iv;
        ones = 0;
        for (int i = 0; i < 8 * k + 16; i++) begin
            fl = i < 8 || i >= 8 * k + 8;
            sbit(fl ? (i % 8 != 0 && i % 8 != 7) : v[i / 8 - 1][i % 8]);
            if (ones == 5 && !fl) sbit(1'b0);
        end
    endtask
endmodule // hdlrx_line_src
`default_nettype wire

// [test/hdlrx_chk.sv]
// checker of the receiver's register port
`timescale 1ns/10ps
`default_nettype none
module hdlrx_chk (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic acc = psel && penable;                       // access phase
    wire logic rd = acc && !pwrite;                         // read access
    wire logic hit = paddr <= 12'h010 && paddr[1:0] == 2'h0; // mapped word
    property p_ready; pready == acc; endproperty
    a_ready: assert property (p_ready) else $error("ready wrong");
    property p_unmap; acc && !hit |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("no slverr");
    property p_map; acc && hit |-> !pslverr; endproperty
    a_map: assert property (p_map) else $error("bad slverr");
    property p_hold; rd |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("prdata moved");
    property p_unz; rd && !hit |-> prdata == 32'h0; endproperty
    a_unz: assert property (p_unz) else $error("unmapped data");
    property p_upper; rd && paddr == 12'h010 |-> prdata[31:13] == 19'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("entry upper");
    property p_inval; rd && paddr == 12'h010 && prdata[12]
        |-> prdata[11:0] == 12'h0; endproperty
    a_inval: assert property (p_inval) else $error("invalid entry");
    property p_flags; rd && paddr == 12'h008 |-> prdata[0] ==
        (prdata[24:16] == 9'h0) && prdata[2] == (prdata[24:16] == 9'h100);
    endproperty
    a_flags: assert property (p_flags) else $error("fill flags");
    c_empty: cover property (rd && paddr == 12'h010 && prdata[12]);
    c_start: cover property (rd && paddr == 12'h010 && prdata[8]);
    c_unmap: cover property (acc && !hit);
endmodule // hdlrx_chk
bind hdlrx_receiver hdlrx_chk u_chk (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// [test/test_hdlc_overhead_receiver.sv]
// self-checking bench of the overhead receiver
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_overhead_receiver;
    logic        mclk, nrst, psel, penable, pwrite; // clock, reset, apb
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat;                      // rdat: last read
    logic        rerr;                              // last pslverr
    logic [7:0]  pk [0:5];                          // packet incl fcs
    wire  logic  pready, pslverr, lck, ldat, pck, pdat;
    wire  logic [31:0] prdata;
    int          err_total, num_checks;
    hdlrx_line_src lsrc (.mclk(mclk), .bclk(lck), .bdat(ldat));
    hdlrx_line_src psrc (.mclk(mclk), .bclk(pck), .bdat(pdat));
    hdlrx_receiver dut (.mclk(mclk), .nrst(nrst), .lineClk(lck),
        .lineData(ldat), .plcpClk(pck), .plcpData(pdat), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reflected crc over pk, inverted as sent on the line
    function automatic logic [15:0] crc(input int n);
        logic [15:0] c = 16'hffff;
        for (int i = 0; i < n * 8; i++)
            c = (c >> 1) ^ ((c[0] ^ pk[i / 8][i % 8]) ? 16'h8408 : 16'h0);
        return ~c;
    endfunction
    task t_reset();
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h0, rdat);
        apb(1'b0, 12'h004, 32'h0);
        chk("thresh", 32'h1, rdat);
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
    endtask
    // send a frame on the selected source, then drain and judge it
    task frame(input logic [3:0] ct, input int n, input logic bad);
        logic [15:0] f;
        logic [7:0]  b;
        int          m;
        apb(1'b1, 12'h000, {28'h0, ct});
        f = crc(n) ^ {15'h0, bad};
        pk[n] = f[7:0];
        pk[n + 1] = f[15:8];
        m = (ct[2] || n > 1) ? n : 0; // under sixteen bits is dropped
        if (ct[1])
            psrc.sframe(pk, n + 2 * ct[2], ct[0]);
        else
            lsrc.sframe(pk, n + 2 * ct[2], ct[0]);
        repeat (20) @(posedge mclk);
        apb(1'b0, 12'h008, 32'h0);
        chk("status", {7'h0, m[8:0], 14'h0, m >= 1, m == 0}, rdat);
        for (int i = 0; i < m; i++) begin
            b = ct[3] ? {<<{pk[i]}} : pk[i];
            apb(1'b0, 12'h010, 32'h0);
            chk("entry", {20'h0, bad && i == m - 1, 1'b0, i == m - 1,
                i == 0, b}, rdat);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("empty read", 32'h1000, rdat);
        apb(1'b0, 12'h00c, 32'h0);
        chk("sticky", {29'h0, bad, 2'b10}, rdat);
        apb(1'b1, 12'h00c, 32'hf);
    endtask
    // packet cut by an abort (s=31,k=7) or a short last byte (s=27,k=6)
    task t_cut(input int s, input int k);
        for (int i = 0; i < s + k + 2; i++)
            lsrc.sbit(i > 0 && i < 7 || i > s && i <= s + k);
        repeat (20) @(posedge mclk);
        apb(1'b0, 12'h010, 32'h0);
        chk("cut first", 32'h100, rdat);
        apb(1'b0, 12'h010, 32'h0);
        chk("cut last", 32'h600, rdat);
        apb(1'b0, 12'h00c, 32'h0);
        chk("cut sticky", 32'h8, rdat);
        apb(1'b1, 12'h00c, 32'hf);
    endtask
    task finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, nrst} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        err_total = 0;
        num_checks = 0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        pk = '{8'hff, 8'h3e, 8'h81, 8'h00, 8'h00, 8'h00};
        frame(4'h0, 3, 1'b0);
        frame(4'hb, 2, 1'b0);
        frame(4'h4, 3, 1'b0);
        frame(4'h4, 2, 1'b1);
        frame(4'h0, 1, 1'b0);
        t_cut(31, 7);
        t_cut(27, 6);
        finish_test();
    end
    // watchdog: the whole run needs well under this span
    initial begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule // test_hdlc_overhead_receiver
`default_nettype wire
